// ---- scr_defines.svh ----
// register offsets, reset values, field positions and timing constants for the config bank
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

`define SCR_ADDR_W          8
`define SCR_OFS_DELAY_CODES 8'h0E
`define SCR_OFS_UNLOCK_KEY  8'h10
`define SCR_OFS_SYS_CONFIG  8'h11
`define SCR_OFS_USER_USER_SCRATCH_BYTE_0  8'h20
`define SCR_OFS_USER_USER_SCRATCH_BYTE_1  8'h21
`define SCR_OFS_USER_USER_SCRATCH_BYTE_2  8'h22
`define SCR_OFS_SW_CONTROL  8'h12

`define SCR_RST_DELAY_CODES 8'h07
`define SCR_RST_ZERO        8'h00

`define SCR_KEY_FIRST       8'hBA
`define SCR_KEY_SECOND      8'hBE
`define SCR_KEY_LOCK        8'h00

`define SCR_OFS_CODE_HI     7
`define SCR_OFS_CODE_LO     4
`define SCR_BIAS_CODE_HI    3
`define SCR_BIAS_CODE_LO    0
`define SCR_BIT_COMMIT      2
`define SCR_BIT_DIRECT      1
`define SCR_SYS_USED_MASK   8'h06
`define SCR_SW_USED_MASK    8'h03

// delay table minimum times in tenths of a microsecond
`define SCR_CLK_MHZ         100
`define SCR_TENTHS_PER_US   10
`define SCR_USER_BYTES      3
`define SCR_DLY_0  40
`define SCR_DLY_1  80
`define SCR_DLY_2  160
`define SCR_DLY_3  320
`define SCR_DLY_4  640
`define SCR_DLY_5  1280
`define SCR_DLY_6  2560
`define SCR_DLY_7  5120
`define SCR_DLY_8  62
`define SCR_DLY_9  124
`define SCR_DLY_10 249
`define SCR_DLY_11 498
`define SCR_DLY_12 995
`define SCR_DLY_13 1991
`define SCR_DLY_14 3983
`define SCR_DLY_15 10242
`define SCR_CYC_W  20

`endif

// ---- scr_host_model.sv ----
// host side model: register port master, one strobe per cycle, queues expected read values
`timescale 1ns/10ps
module scr_host_model (
	input  wire logic          core_clk,  // clock
	output logic [7:0]         reg_addr,  // offset
	output scr_pkg::scr_byte_t reg_wdata, // data
	output logic               reg_wr,    // write
	output logic               reg_rd     // read
);
	import scr_pkg::*;
	scr_byte_t exp_q[$];
	// quiet bus from time zero so nothing is taken during reset
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// strobe stays up until the next call, so no signal is assigned twice in one step
	task automatic wr(input logic [7:0] a, input scr_byte_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input scr_byte_t e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
	endtask
	// released data lines toggle so a stale value never looks valid
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wdata <= ~reg_wdata;
		repeat (n) @(posedge core_clk);
	endtask
endmodule

// ---- scr_pkg.sv ----
// types shared by the sequencing config bank
package scr_pkg;
	typedef enum logic [2:0] {
		SCR_LOCKED   = 3'b001,
		SCR_HALF_KEY = 3'b010,
		SCR_UNLOCKED = 3'b100
	} scr_lock_t;
	typedef logic [7:0] scr_byte_t;
endpackage

// ---- scr_sequencing_config_regs.sv ----
// configuration register bank: sequencing delay codes, keyed system config, user scratch bytes
// Summary of operation
// [RULE_01] upper nibble of delay register is offset rail / mirror reset release delay code
// [RULE_02] lower nibble of delay register is bias rail / reset rail delay code
// [RULE_03] each code maps to a wait time from the fixed doubling table
// [RULE_04] key 0xBA then 0xBE unlocks; writing 0x00 locks again
// [RULE_05] system config register accepts writes only while unlocked
// [RULE_06] setting commit bit copies scratch bytes into non-volatile storage
// [RULE_07] manual mode lets switch control register drive channel switches directly
// [RULE_08] user bytes 0 to 2 at 20h..22h, read-write, reset to zero
// [RULE_09] locked writes to system config ignored; unused bits read zero
`timescale 1ns/10ps
`include "scr_defines.svh"

module scr_sequencing_config_regs (
	input  wire logic                     core_clk,           // 100 MHz core clock
	input  wire logic                     nrst,               // synchronous reset, active low
	input  wire logic [`SCR_ADDR_W-1:0]   reg_addr,           // register offset
	input  wire scr_pkg::scr_byte_t       reg_wdata,          // write data
	input  wire logic                     reg_wr,             // write strobe
	input  wire logic                     reg_rd,             // read strobe
	output scr_pkg::scr_byte_t            reg_rdata,          // read data, cycle after strobe
	input  wire logic [1:0]               channel_select_pins,// automatic channel selection
	output logic [3:0]                    offset_step_delay_code, // offset rail step code
	output logic [3:0]                    bias_step_delay_code,   // bias rail step code
	output logic [`SCR_CYC_W-1:0]         offset_step_cycles, // offset step wait in cycles
	output logic [`SCR_CYC_W-1:0]         bias_step_cycles,   // bias step wait in cycles
	output logic                          cfg_unlocked,       // key sequence complete
	output logic                          manual_switch_mode, // direct switch control active
	output logic [1:0]                    switch_drive,       // channel switch selection
	output logic                          nvm_write_req,      // one-cycle commit pulse
	output scr_pkg::scr_byte_t            nvm_user_scratch_byte_0,          // committed byte 0
	output scr_pkg::scr_byte_t            nvm_user_scratch_byte_1,          // committed byte 1
	output scr_pkg::scr_byte_t            nvm_user_scratch_byte_2           // committed byte 2
);
	import scr_pkg::*;

	scr_byte_t delay_codes_ff;
	scr_byte_t unlock_key_ff;
	scr_byte_t sys_config_ff;
	scr_byte_t sw_control_ff;
	scr_byte_t user_ff [0:2];
	scr_byte_t nvm_ff [0:2];
	scr_lock_t lock_ff;
	scr_lock_t nxt_lock;
	scr_byte_t rdata_ff;
	scr_byte_t nxt_rdata;
	logic      commit_ff;
	logic [`SCR_CYC_W-1:0] ofs_cyc_ff;
	logic [`SCR_CYC_W-1:0] bias_cyc_ff;

	logic wr_delay;
	logic wr_key;
	logic wr_sys;
	logic wr_sw;
	logic [2:0] wr_user;

	// address decode of writes
	always_comb begin
		wr_delay = 1'b0;
		wr_key   = 1'b0;
		wr_sys   = 1'b0;
		wr_sw    = 1'b0;
		wr_user  = 3'b000;
		if (reg_wr && reg_addr == `SCR_OFS_DELAY_CODES) begin
			wr_delay = 1'b1;
		end else if (reg_wr && reg_addr == `SCR_OFS_UNLOCK_KEY) begin
			wr_key = 1'b1;
		end else if (reg_wr && reg_addr == `SCR_OFS_SYS_CONFIG) begin
			wr_sys = 1'b1;
		end else if (reg_wr && reg_addr == `SCR_OFS_SW_CONTROL) begin
			wr_sw = 1'b1;
		end else if (reg_wr && reg_addr == `SCR_OFS_USER_USER_SCRATCH_BYTE_0) begin
			wr_user = 3'b001;
		end else if (reg_wr && reg_addr == `SCR_OFS_USER_USER_SCRATCH_BYTE_1) begin
			wr_user = 3'b010;
		end else if (reg_wr && reg_addr == `SCR_OFS_USER_USER_SCRATCH_BYTE_2) begin
			wr_user = 3'b100;
		end
	end

	// delay code register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			delay_codes_ff <= `SCR_RST_DELAY_CODES;
		end else if (wr_delay) begin
			delay_codes_ff <= reg_wdata; // [RULE_01] [RULE_02]
		end
	end

	// one translator per field; registered so the table stays off the output path,
	// at the cost of the wait count trailing its code by one cycle
	scr_delay_xlate #(
		.CYC_W(`SCR_CYC_W)
	) i_ofs_xlate (
		.core_clk(core_clk),
		.nrst    (nrst),
		.code    (delay_codes_ff[`SCR_OFS_CODE_HI:`SCR_OFS_CODE_LO]), // [RULE_03]
		.cycles  (ofs_cyc_ff)
	);

	// the bias step uses its own copy of the same table
	scr_delay_xlate #(
		.CYC_W(`SCR_CYC_W)
	) i_bias_xlate (
		.core_clk(core_clk),
		.nrst    (nrst),
		.code    (delay_codes_ff[`SCR_BIAS_CODE_HI:`SCR_BIAS_CODE_LO]), // [RULE_03]
		.cycles  (bias_cyc_ff)
	);

	// key sequence as a three-state machine; a stray value mid-sequence starts over,
	// though half a key lingers through writes to other offsets until the next key write
	always_comb begin
		nxt_lock = lock_ff;
		case (lock_ff)
			SCR_LOCKED: begin
				if (wr_key && reg_wdata == `SCR_KEY_FIRST) begin
					nxt_lock = SCR_HALF_KEY; // [RULE_04]
				end
			end
			SCR_HALF_KEY: begin
				if (wr_key && reg_wdata == `SCR_KEY_SECOND) begin
					nxt_lock = SCR_UNLOCKED; // [RULE_04]
				end else if (wr_key && reg_wdata != `SCR_KEY_FIRST) begin
					nxt_lock = SCR_LOCKED;
				end
			end
			SCR_UNLOCKED: begin
				// only the lock value closes it again; other key writes keep it open
				if (wr_key && reg_wdata == `SCR_KEY_LOCK) begin
					nxt_lock = SCR_LOCKED; // [RULE_04]
				end
			end
			default: begin
				nxt_lock = SCR_LOCKED; // an illegal code falls back to the safe state
			end
		endcase
	end

	// lock state and key register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			lock_ff       <= SCR_LOCKED;
			unlock_key_ff <= `SCR_RST_ZERO;
		end else begin
			lock_ff <= nxt_lock;
			if (wr_key) begin
				unlock_key_ff <= reg_wdata;
			end
		end
	end

	// protected config; locked writes are dropped silently
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sys_config_ff <= `SCR_RST_ZERO;
		end else if (wr_sys && lock_ff == SCR_UNLOCKED) begin // [RULE_05] [RULE_09]
			sys_config_ff <= reg_wdata & `SCR_SYS_USED_MASK; // [RULE_09]
		end else if (commit_ff) begin
			sys_config_ff[`SCR_BIT_COMMIT] <= 1'b0; // commit bit self-clears once done
		end
	end

	// commit pulse on an accepted write with the commit bit set
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			commit_ff <= 1'b0;
		end else begin
			commit_ff <= wr_sys && lock_ff == SCR_UNLOCKED && reg_wdata[`SCR_BIT_COMMIT]; // [RULE_06]
		end
	end

	// switch control register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sw_control_ff <= `SCR_RST_ZERO;
		end else if (wr_sw) begin
			sw_control_ff <= reg_wdata & `SCR_SW_USED_MASK;
		end
	end

	// user scratch bytes and their non-volatile copies, one cell per byte;
	// the copy loads only on the commit pulse, so later scratch edits leave it alone
	for (genvar i = 0; i < `SCR_USER_BYTES; i++) begin : g_user
		scr_byte_cell #(
			.RST_VAL(`SCR_RST_ZERO)
		) i_scratch (
			.core_clk(core_clk),
			.nrst    (nrst),
			.load    (wr_user[i]), // [RULE_08]
			.din     (reg_wdata),
			.q       (user_ff[i])
		);
		scr_byte_cell #(
			.RST_VAL(`SCR_RST_ZERO)
		) i_stored (
			.core_clk(core_clk),
			.nrst    (nrst),
			.load    (commit_ff), // [RULE_06]
			.din     (user_ff[i]),
			.q       (nvm_ff[i])
		);
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		nxt_rdata = `SCR_RST_ZERO;
		if (reg_addr == `SCR_OFS_DELAY_CODES) begin
			nxt_rdata = delay_codes_ff; // [RULE_01] [RULE_02]
		end else if (reg_addr == `SCR_OFS_UNLOCK_KEY) begin
			nxt_rdata = unlock_key_ff;
		end else if (reg_addr == `SCR_OFS_SYS_CONFIG) begin
			nxt_rdata = sys_config_ff; // [RULE_09]
		end else if (reg_addr == `SCR_OFS_SW_CONTROL) begin
			nxt_rdata = sw_control_ff;
		end else if (reg_addr == `SCR_OFS_USER_USER_SCRATCH_BYTE_0) begin
			nxt_rdata = user_ff[0];
		end else if (reg_addr == `SCR_OFS_USER_USER_SCRATCH_BYTE_1) begin
			nxt_rdata = user_ff[1];
		end else if (reg_addr == `SCR_OFS_USER_USER_SCRATCH_BYTE_2) begin
			nxt_rdata = user_ff[2];
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_ff <= `SCR_RST_ZERO;
		end else begin
			rdata_ff <= reg_rd ? nxt_rdata : `SCR_RST_ZERO;
		end
	end

	assign reg_rdata              = rdata_ff;
	assign offset_step_delay_code = delay_codes_ff[`SCR_OFS_CODE_HI:`SCR_OFS_CODE_LO];
	assign bias_step_delay_code   = delay_codes_ff[`SCR_BIAS_CODE_HI:`SCR_BIAS_CODE_LO];
	assign offset_step_cycles     = ofs_cyc_ff;
	assign bias_step_cycles       = bias_cyc_ff;
	assign cfg_unlocked           = (lock_ff == SCR_UNLOCKED);
	assign manual_switch_mode     = sys_config_ff[`SCR_BIT_DIRECT];
	// manual mode hands the switches to software instead of the select pins
	assign switch_drive = manual_switch_mode ? sw_control_ff[1:0] : channel_select_pins; // [RULE_07]
	assign nvm_write_req          = commit_ff;
	assign nvm_user_scratch_byte_0              = nvm_ff[0];
	assign nvm_user_scratch_byte_1              = nvm_ff[1];
	assign nvm_user_scratch_byte_2              = nvm_ff[2];
endmodule

// translates one four-bit delay code into its minimum wait in core clock cycles
module scr_delay_xlate #(
	parameter int CYC_W = `SCR_CYC_W // width of the cycle count
) (
	input  wire logic        core_clk, // core clock
	input  wire logic        nrst,     // synchronous reset, active low
	input  wire logic [3:0]  code,     // delay code from the timing register
	output logic [CYC_W-1:0] cycles    // minimum wait, registered
);
	import scr_pkg::*;

	int               tenths;
	int               nxt_cycles;
	logic [CYC_W-1:0] cyc_ff;

	// the lower codes double from one base, the upper ones from another, and the
	// last code breaks the pattern, so a lookup is clearer than arithmetic
	always_comb begin
		tenths = `SCR_DLY_15;
		case (code)
			4'h0: tenths = `SCR_DLY_0;
			4'h1: tenths = `SCR_DLY_1;
			4'h2: tenths = `SCR_DLY_2;
			4'h3: tenths = `SCR_DLY_3;
			4'h4: tenths = `SCR_DLY_4;
			4'h5: tenths = `SCR_DLY_5;
			4'h6: tenths = `SCR_DLY_6;
			4'h7: tenths = `SCR_DLY_7;
			4'h8: tenths = `SCR_DLY_8;
			4'h9: tenths = `SCR_DLY_9;
			4'hA: tenths = `SCR_DLY_10;
			4'hB: tenths = `SCR_DLY_11;
			4'hC: tenths = `SCR_DLY_12;
			4'hD: tenths = `SCR_DLY_13;
			4'hE: tenths = `SCR_DLY_14;
			default: tenths = `SCR_DLY_15;
		endcase
		// round up so a wait is never shorter than the floor of its band
		nxt_cycles = (tenths * `SCR_CLK_MHZ + `SCR_TENTHS_PER_US - 1) / `SCR_TENTHS_PER_US;
	end

	// only the floor is produced; stretching toward the top of the band is the
	// sequencer's business, not this table's
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cyc_ff <= '0;
		end else begin
			cyc_ff <= CYC_W'(nxt_cycles); // [RULE_03]
		end
	end

	assign cycles = cyc_ff;
endmodule

// one eight-bit register with a load strobe, used for each user byte and its stored copy
module scr_byte_cell #(
	parameter scr_pkg::scr_byte_t RST_VAL = `SCR_RST_ZERO // value after reset
) (
	input  wire logic               core_clk, // core clock
	input  wire logic               nrst,     // synchronous reset, active low
	input  wire logic               load,     // take a new value this cycle
	input  wire scr_pkg::scr_byte_t din,      // value to take
	output scr_pkg::scr_byte_t      q         // held value
);
	import scr_pkg::*;

	scr_byte_t val_ff;

	// plain load register; reset puts it back to its documented value
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			val_ff <= RST_VAL;
		end else if (load) begin
			val_ff <= din;
		end
	end

	assign q = val_ff;
endmodule

// ---- scr_sequencing_config_regs_monitor.sv ----
// assertion checker for the sequencing config bank, bound to its ports
`timescale 1ns/10ps
`include "scr_defines.svh"
module scr_cfg_monitor (
	input wire logic                   core_clk,               // clock
	input wire logic                   nrst,                   // reset
	input wire logic [7:0]             reg_addr,               // offset
	input wire scr_pkg::scr_byte_t     reg_wdata,              // data
	input wire logic                   reg_wr,                 // write
	input wire logic                   reg_rd,                 // read
	input wire scr_pkg::scr_byte_t     reg_rdata,              // answer
	input wire logic [1:0]             channel_select_pins,    // auto select
	input wire logic [3:0]             offset_step_delay_code, // upper code
	input wire logic [3:0]             bias_step_delay_code,   // lower code
	input wire logic [`SCR_CYC_W-1:0]  offset_step_cycles,     // upper wait
	input wire logic [`SCR_CYC_W-1:0]  bias_step_cycles,       // lower wait
	input wire logic                   cfg_unlocked,           // key state
	input wire logic                   manual_switch_mode,     // direct mode
	input wire logic [1:0]             switch_drive,           // switch select
	input wire logic                   nvm_write_req           // commit pulse
);
	localparam logic [`SCR_CYC_W-1:0] CYC [16] = '{20'h00190, 20'h00320, 20'h00640,
		20'h00C80, 20'h01900, 20'h03200, 20'h06400, 20'h0C800, 20'h0026C, 20'h004D8,
		20'h009BA, 20'h01374, 20'h026DE, 20'h04DC6, 20'h09B96, 20'h19014};
	logic w_key;
	logic w_sys;
	logic w_ba;
	logic w_d1;
	logic w_map;
	// decoded write kinds, kept apart so $past sees plain signals
	assign w_key = reg_wr && reg_addr == 8'h10;
	assign w_sys = reg_wr && reg_addr == 8'h11;
	assign w_ba = w_key && reg_wdata == 8'hBA;
	assign w_d1 = reg_wdata[1];
	assign w_map = reg_addr inside {8'h0E, 8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22};
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	a_delay_field: assert property (
		reg_wr && reg_addr == 8'h0E |=> {offset_step_delay_code, bias_step_delay_code}
		== $past(reg_wdata)) else $error("delay codes not stored");
	a_code_cycles: assert property (
		$past(nrst) |-> offset_step_cycles == CYC[$past(offset_step_delay_code)]
		&& bias_step_cycles == CYC[$past(bias_step_delay_code)]) else $error("bad wait");
	a_key_unlock: assert property (
		w_key && reg_wdata == 8'hBE && $past(w_ba) |=> cfg_unlocked) else $error("no unlock");
	a_key_relock: assert property (
		w_key && reg_wdata == 8'h00 |=> !cfg_unlocked) else $error("no relock");
	a_locked_sys: assert property (
		w_sys && !cfg_unlocked |=> $stable(manual_switch_mode) && !nvm_write_req)
		else $error("locked write landed");
	a_commit_pulse: assert property (
		w_sys && cfg_unlocked && reg_wdata[2] |=> nvm_write_req ##1 !nvm_write_req)
		else $error("commit pulse wrong");
	a_direct_bit: assert property (
		w_sys && cfg_unlocked |=> manual_switch_mode == $past(w_d1)) else $error("mode bit");
	a_auto_select: assert property (
		!manual_switch_mode |-> switch_drive == channel_select_pins) else $error("auto sel");
	a_read_quiet: assert property (
		!$past(reg_rd) || !$past(w_map) |-> reg_rdata == 8'h00) else $error("stray data");
	c_unlock: cover property (w_key && reg_wdata == 8'hBE && $past(w_ba));
	c_commit: cover property (nvm_write_req);
	c_manual: cover property (manual_switch_mode && reg_wr && reg_addr == 8'h12);
endmodule
bind scr_sequencing_config_regs scr_cfg_monitor i_mon (.core_clk(core_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .channel_select_pins(channel_select_pins),
	.offset_step_delay_code(offset_step_delay_code), .bias_step_delay_code(bias_step_delay_code),
	.offset_step_cycles(offset_step_cycles), .bias_step_cycles(bias_step_cycles),
	.cfg_unlocked(cfg_unlocked), .manual_switch_mode(manual_switch_mode),
	.switch_drive(switch_drive), .nvm_write_req(nvm_write_req));

// ---- scr_sequencing_config_regs_tb_top.sv ----
// self-checking bench for the sequencing config bank
`timescale 1ns/10ps
module scr_sequencing_config_regs_tb_top;
	import scr_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr;
	scr_byte_t wdat, rdat, ub [3], nvm_b [3];
	logic wr, rd, rd_pend, unl, man, req;
	logic [1:0] csel = 2'h0;
	logic [1:0] drv, sw;
	logic [3:0] ocode, bcode;
	logic [19:0] ocyc, bcyc;
	int fails = 0;
	int checks_done = 0;
	int pulses = 0;
	// count commit pulses mid-cycle, where the registered pulse has settled
	always @(negedge core_clk) if (req === 1'b1) pulses++;
	logic [19:0] cyc [16] = '{20'h00190, 20'h00320, 20'h00640, 20'h00C80, 20'h01900,
		20'h03200, 20'h06400, 20'h0C800, 20'h0026C, 20'h004D8, 20'h009BA, 20'h01374,
		20'h026DE, 20'h04DC6, 20'h09B96, 20'h19014};
	scr_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(wdat),
		.reg_wr(wr), .reg_rd(rd));
	scr_sequencing_config_regs i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(wdat), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
		.channel_select_pins(csel), .offset_step_delay_code(ocode),
		.bias_step_delay_code(bcode), .offset_step_cycles(ocyc), .bias_step_cycles(bcyc),
		.cfg_unlocked(unl), .manual_switch_mode(man), .switch_drive(drv),
		.nvm_write_req(req), .nvm_user_scratch_byte_0(nvm_b[0]), .nvm_user_scratch_byte_1(nvm_b[1]), .nvm_user_scratch_byte_2(nvm_b[2]));
	always #5 core_clk = ~core_clk;
	// automatic selection keeps moving so direct mode must really override it
	always @(posedge core_clk) csel <= 2'($urandom);
	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic settle(input int n);
		i_host.idle(n);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// read answers stand only in the cycle after the strobe, so look mid-cycle
	always @(negedge core_clk) begin
		if (rd_pend)
			chk("read data", i_host.exp_q.pop_front(), rdat);
		rd_pend = rd;
	end
	// a hang ends the run as a mismatch
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		give_verdict();
	end
	initial begin
		rd_pend = 1'b0;
		void'($urandom(71311));
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		i_host.rd(8'h0E, 8'h07);
		for (int i = 0; i < 3; i++) i_host.rd(8'(8'h20 + i), 8'h00);
		i_host.rd(8'h30, 8'h00);
		settle(2);
		chk("bias cycles", 20'h0C800, bcyc);
		chk("offset cycles", 20'h00190, ocyc);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			i_host.wr(8'h0E, {4'(c), 4'(15 - c)});
			settle(2);
			chk("offset code", 20'(c), 20'(ocode));
			chk("bias code", 20'(15 - c), 20'(bcode));
			chk("offset cycles", cyc[c], ocyc);
			chk("bias cycles", cyc[15 - c], bcyc);
		end
		i_host.rd(8'h0E, 8'hF0);
		$display("test delay codes done");
		i_host.wr(8'h11, 8'h06);
		i_host.rd(8'h11, 8'h00);
		i_host.wr(8'h10, 8'hBA);
		i_host.wr(8'h10, 8'hBE);
		settle(1);
		chk("unlocked", 20'h00001, 20'(unl));
		for (int i = 0; i < 3; i++) begin
			ub[i] = 8'($urandom);
			i_host.wr(8'(8'h20 + i), ub[i]);
		end
		i_host.wr(8'h11, 8'hFF);
		settle(2);
		for (int i = 0; i < 3; i++) chk("stored byte", 20'(ub[i]), 20'(nvm_b[i]));
		chk("commit pulses", 20'h00001, 20'(pulses));
		chk("manual mode", 20'h00001, 20'(man));
		i_host.rd(8'h11, 8'h02);
		for (int i = 0; i < 3; i++) i_host.rd(8'(8'h20 + i), ub[i]);
		sw = 2'($urandom);
		i_host.wr(8'h12, {6'h00, sw});
		settle(1);
		chk("switch drive", 20'(sw), 20'(drv));
		$display("test unlock and commit done");
		i_host.wr(8'h10, 8'h00);
		i_host.wr(8'h11, 8'h00);
		i_host.rd(8'h11, 8'h02);
		settle(2);
		chk("unlocked", 20'h00000, 20'(unl));
		chk("manual mode", 20'h00001, 20'(man));
		chk("commit pulses", 20'h00001, 20'(pulses));
		$display("test relock done");
		give_verdict();
	end
endmodule
